// ---- hdl/csm_consts.vh ----
`ifndef CSM_CONSTS_VH
`define CSM_CONSTS_VH

// Register byte offsets.
`define CSM_OFS_CTRL        8'h00
`define CSM_OFS_STATUS      8'h04
`define CSM_OFS_MASK        8'h08
`define CSM_OFS_STATE       8'h0c

// Control register fields.
`define CSM_CTRL_DET_EN     0
`define CSM_CTRL_VARIANT    1
`define CSM_CTRL_RESET      8'h00

// Status and mask register fields.
`define CSM_ST_STOP         0
`define CSM_STATUS_RESET    8'h00
`define CSM_MASK_RESET      8'h00

// State register fields.
`define CSM_SV_STOPPED      0
`define CSM_SV_SUPPRESS     1
`define CSM_SV_ON_LOW_SPEED_INTERNAL_OSC      2
`define CSM_SV_PLL_FREE     3
`define CSM_SV_USB_FREE     4
`define CSM_SV_VARIANT      5

// System clock source codes.
`define CSM_SRC_MAIN        2'h0
`define CSM_SRC_PLL         2'h1
`define CSM_SRC_LOW_SPEED_INTERNAL_OSC        2'h2

// Timing.
`define CSM_CLK_PERIOD_NS   40
`define CSM_STOP_TIME_NS    1000
`define CSM_STAB_TIME_US    1000
`define CSM_STOP_CYCLES     ((`CSM_STOP_TIME_NS + `CSM_CLK_PERIOD_NS - 1) / `CSM_CLK_PERIOD_NS)
`define CSM_STAB_CYCLES     ((`CSM_STAB_TIME_US * 1000 + `CSM_CLK_PERIOD_NS - 1) / `CSM_CLK_PERIOD_NS)

`endif

// ---- hdl/csm_edge_watch.v ----
`timescale 1ns/1ps
`include "csm_consts.vh"

// Flags the watched clock as stopped when no level change is seen for LIMIT cycles.
module csm_edge_watch #(
    parameter CW    = 16,
    parameter LIMIT = `CSM_STOP_CYCLES
) (
    input  wire sys_clk,
    input  wire rst_b,
    input  wire watch_in,
    input  wire hold_clear,
    output wire stopped
);
    localparam [CW-1:0] LIMIT_C = LIMIT[CW-1:0];

    reg          last_reg;
    reg [CW-1:0] idle_reg;
    reg [CW-1:0] idle_next;
    reg          stop_reg;
    reg          stop_next;

    always @* begin
        idle_next = idle_reg;
        stop_next = stop_reg;
        if (hold_clear || (watch_in != last_reg)) begin
            idle_next = {CW{1'b0}};
            stop_next = 1'b0;
        end else if (idle_reg < LIMIT_C) begin
            idle_next = idle_reg + {{(CW-1){1'b0}}, 1'b1};
        end else begin
            stop_next = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            last_reg <= 1'b0;
            idle_reg <= {CW{1'b0}};
            stop_reg <= 1'b0;
        end else begin
            last_reg <= watch_in;
            idle_reg <= idle_next;
            stop_reg <= stop_next;
        end
    end

    assign stopped = stop_reg;
endmodule // csm_edge_watch

// ---- hdl/csm_clock_stop_monitor.v ----
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "csm_consts.vh"

// What this block does
// [RL1] Reset-response variant: a detected main clock stop issues a system reset request.
// [RL2] Switchover variant: main clock selected and stopped, move system clock to internal oscillator, interrupt.
// [RL3] Switchover variant: PLL selected and reference stopped, let PLL free-run, interrupt.
// [RL4] Switchover variant: USB PLL in use and reference stopped, let USB PLL free-run, interrupt.
// [RL5] Stop interrupt is non-maskable; the mask register cannot block it.
// [RL6] Reset-response variant: no detection from deep stop entry until stabilization wait elapses.
// [RL7] Reset-response variant: no detection while the sampling oscillator is halted.
// [RL8] Reset-response variant: no detection while the CPU runs from the internal oscillator.
// [RL9] Reset-response variant: no detection while software holds the main oscillator halted.
// [RL10] Software disables detection before stopping the main clock in switchover variant.
// [RL11] Switchover variant suppresses nothing; an intentional stop is reported like a failure.
module csm_clock_stop_monitor #(
    parameter STAB_CYCLES = `CSM_STAB_CYCLES,
    parameter STAB_W      = 16,
    parameter STOP_W      = 16
) (
    input  wire       sys_clk,
    input  wire       rst_b,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output wire [7:0] reg_rdata,
    input  wire       main_osc_in,
    input  wire [1:0] sys_clk_src,
    input  wire       usb_pll_in_use,
    input  wire       deep_stop,
    input  wire       sample_osc_halted,
    input  wire       cpu_on_internal_osc,
    input  wire       main_osc_halt_bit,
    output wire       sys_reset_req,
    output wire       switch_to_low_speed_internal_osc,
    output wire       pll_free_run,
    output wire       usb_pll_free_run,
    output wire       nmi_req,
    output wire       irq
);
    localparam [STAB_W-1:0] STAB_C = STAB_CYCLES[STAB_W-1:0];

    // One-hot monitor states.
    localparam [2:0] ST_WATCH = 3'b001;
    localparam [2:0] ST_HIT   = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;

    reg  [7:0]        ctrl_reg;
    reg  [7:0]        status_reg;
    reg  [7:0]        status_next;
    reg  [7:0]        mask_reg;
    reg  [7:0]        rdata_reg;
    reg  [7:0]        rdata_next;
    reg  [STAB_W-1:0] stab_reg;
    reg  [STAB_W-1:0] stab_next;
    reg  [2:0]        state_reg;
    reg  [2:0]        state_next;
    reg               stopped_d_reg;
    reg               rst_req_reg;
    reg               rst_req_next;
    reg               on_low_speed_internal_osc_reg;
    reg               on_low_speed_internal_osc_next;
    reg               pll_free_reg;
    reg               pll_free_next;
    reg               usb_free_reg;
    reg               usb_free_next;

    wire det_en;
    wire variant_sw;
    wire in_stab;
    wire suppress;
    wire stopped;
    wire stop_event;
    wire stop_w1c;

    assign det_en     = ctrl_reg[`CSM_CTRL_DET_EN];
    assign variant_sw = ctrl_reg[`CSM_CTRL_VARIANT];
    assign in_stab    = deep_stop || (stab_reg != {STAB_W{1'b0}});

    // Suppression applies to the reset-response variant only.
    assign suppress = !variant_sw && (in_stab           // [RL6]
                                      || sample_osc_halted   // [RL7]
                                      || cpu_on_internal_osc // [RL8]
                                      || main_osc_halt_bit); // [RL9]

    // The watcher is held clear while suppressed or disabled, so a stale idle count cannot fire on release.
    // The switchover variant reports every stop once enabled, deliberate or not. [RL11]
    csm_edge_watch #(
        .CW    (STOP_W),
        .LIMIT (`CSM_STOP_CYCLES)
    ) u_watch (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .watch_in   (main_osc_in),
        .hold_clear (suppress || !det_en),
        .stopped    (stopped)
    );

    assign stop_event = stopped && !stopped_d_reg && (state_reg == ST_WATCH);
    assign stop_w1c   = reg_wr && (reg_addr == `CSM_OFS_STATUS) && reg_wdata[`CSM_ST_STOP];

    // Stabilization wait reloads for as long as deep stop lasts and runs down after it ends.
    always @* begin
        stab_next = stab_reg;
        if (deep_stop) begin
            stab_next = STAB_C;
        end else if (stab_reg != {STAB_W{1'b0}}) begin
            stab_next = stab_reg - {{(STAB_W-1){1'b0}}, 1'b1};
        end
    end

    always @* begin
        state_next    = state_reg;
        rst_req_next  = 1'b0;
        on_low_speed_internal_osc_next  = on_low_speed_internal_osc_reg;
        pll_free_next = pll_free_reg;
        usb_free_next = usb_free_reg;
        case (state_reg)
            ST_WATCH: begin
                if (stop_event) begin
                    state_next = ST_HIT;
                end
            end
            ST_HIT: begin
                state_next = ST_DONE;
                if (!variant_sw) begin
                    rst_req_next = 1'b1; // [RL1]
                end else begin
                    if (sys_clk_src == `CSM_SRC_MAIN) begin
                        on_low_speed_internal_osc_next = 1'b1; // [RL2]
                    end
                    if (sys_clk_src == `CSM_SRC_PLL) begin
                        pll_free_next = 1'b1; // [RL3]
                    end
                    if (usb_pll_in_use) begin
                        usb_free_next = 1'b1; // [RL4]
                    end
                end
            end
            ST_DONE: begin
                // Rearm once the clock runs again or detection is dropped; the fallbacks stay until reset.
                if (!stopped) begin
                    state_next = ST_WATCH;
                end
            end
            default: begin
                state_next = ST_WATCH;
            end
        endcase
    end

    // A new stop wins over a write-one-to-clear in the same cycle.
    always @* begin
        status_next = status_reg;
        if (stop_w1c) begin
            status_next[`CSM_ST_STOP] = 1'b0;
        end
        if ((state_reg == ST_HIT) && variant_sw) begin
            status_next[`CSM_ST_STOP] = 1'b1; // [RL2] [RL3] [RL4]
        end
        status_next[7:1] = 7'h00;
    end

    always @* begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `CSM_OFS_CTRL: begin
                    rdata_next = ctrl_reg;
                end
                `CSM_OFS_STATUS: begin
                    rdata_next = status_reg;
                end
                `CSM_OFS_MASK: begin
                    rdata_next = mask_reg;
                end
                `CSM_OFS_STATE: begin
                    rdata_next[`CSM_SV_STOPPED]  = stopped;
                    rdata_next[`CSM_SV_SUPPRESS] = suppress;
                    rdata_next[`CSM_SV_ON_LOW_SPEED_INTERNAL_OSC]  = on_low_speed_internal_osc_reg;
                    rdata_next[`CSM_SV_PLL_FREE] = pll_free_reg;
                    rdata_next[`CSM_SV_USB_FREE] = usb_free_reg;
                    rdata_next[`CSM_SV_VARIANT]  = variant_sw;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_reg      <= `CSM_CTRL_RESET;
            status_reg    <= `CSM_STATUS_RESET;
            mask_reg      <= `CSM_MASK_RESET;
            rdata_reg     <= 8'h00;
            stab_reg      <= {STAB_W{1'b0}};
            state_reg     <= ST_WATCH;
            stopped_d_reg <= 1'b0;
            rst_req_reg   <= 1'b0;
            on_low_speed_internal_osc_reg   <= 1'b0;
            pll_free_reg  <= 1'b0;
            usb_free_reg  <= 1'b0;
        end else begin
            if (reg_wr && (reg_addr == `CSM_OFS_CTRL)) begin
                ctrl_reg <= {6'h00, reg_wdata[1:0]};
            end
            if (reg_wr && (reg_addr == `CSM_OFS_MASK)) begin
                mask_reg <= {7'h00, reg_wdata[0]};
            end
            status_reg    <= status_next;
            rdata_reg     <= rdata_next;
            stab_reg      <= stab_next;
            state_reg     <= state_next;
            stopped_d_reg <= stopped;
            rst_req_reg   <= rst_req_next;
            on_low_speed_internal_osc_reg   <= on_low_speed_internal_osc_next;
            pll_free_reg  <= pll_free_next;
            usb_free_reg  <= usb_free_next;
        end
    end

    assign reg_rdata                        = rdata_reg;
    assign sys_reset_req                    = rst_req_reg;
    assign switch_to_low_speed_internal_osc = on_low_speed_internal_osc_reg;
    assign pll_free_run                     = pll_free_reg;
    assign usb_pll_free_run                 = usb_free_reg;
    // The non-maskable line ignores the mask; only the ordinary line is gated.
    assign nmi_req = status_reg[`CSM_ST_STOP]; // [RL5]
    assign irq     = status_reg[`CSM_ST_STOP] && mask_reg[`CSM_ST_STOP];
endmodule // csm_clock_stop_monitor

// ---- dv/csm_osc_model.sv ----
`timescale 1ns/1ps
module csm_osc_model (
    input  wire  sys_clk,
    input  wire  run,
    output logic osc
);
    // A failed crystal freezes at whatever level it last had, so the stop is a held level.
    logic [1:0] div_reg = 2'h0;
    initial osc = 1'b0;
    always @(posedge sys_clk) begin
        if (run) begin
            div_reg <= div_reg + 2'h1;
            if (div_reg == 2'h1) osc <= ~osc;
        end
    end
endmodule // csm_osc_model

// ---- dv/csm_stop_monitor.sv ----
`timescale 1ns/1ps
`include "csm_consts.vh"
module csm_stop_checker #(
    parameter STAB_CYCLES = 20
) (
    input wire       sys_clk,
    input wire       rst_b,
    input wire       main_osc_in,
    input wire [1:0] sys_clk_src,
    input wire       usb_pll_in_use,
    input wire       deep_stop,
    input wire       sample_osc_halted,
    input wire       cpu_on_internal_osc,
    input wire       main_osc_halt_bit,
    input wire       sys_reset_req,
    input wire       switch_to_low_speed_internal_osc,
    input wire       pll_free_run,
    input wire       usb_pll_free_run,
    input wire       nmi_req,
    input wire       irq
);
    logic        osc_q;
    int unsigned idle_cnt;
    int unsigned stab_cnt;
    // Counters saturate so a long idle stretch cannot wrap and fake activity.
    always @(posedge sys_clk) begin
        osc_q <= main_osc_in;
        if (!rst_b || main_osc_in != osc_q) idle_cnt <= 0;
        else if (idle_cnt < 1000) idle_cnt <= idle_cnt + 1;
        if (!rst_b) stab_cnt <= STAB_CYCLES;
        else if (deep_stop) stab_cnt <= 0;
        else if (stab_cnt < STAB_CYCLES) stab_cnt <= stab_cnt + 1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_fallback;
        $rose(switch_to_low_speed_internal_osc) || $rose(pll_free_run) || $rose(usb_pll_free_run);
    endsequence
    chk_reset_single: assert property (sys_reset_req |=> !sys_reset_req)
        else $error("reset request wider than one cycle");
    chk_reset_quiet: assert property (sys_reset_req |-> idle_cnt >= `CSM_STOP_CYCLES - 2)
        else $error("reset request while main clock still toggled");
    chk_switch_main: assert property ($rose(switch_to_low_speed_internal_osc) |-> $past(sys_clk_src) == `CSM_SRC_MAIN)
        else $error("switch to internal oscillator without main selected");
    chk_switch_held: assert property (switch_to_low_speed_internal_osc |=> switch_to_low_speed_internal_osc)
        else $error("clock switch dropped before reset");
    chk_pll_free: assert property ($rose(pll_free_run) |-> $past(sys_clk_src) == `CSM_SRC_PLL)
        else $error("free run without PLL selected");
    chk_usb_free: assert property ($rose(usb_pll_free_run) |-> $past(usb_pll_in_use))
        else $error("USB free run while USB PLL unused");
    chk_fallback_nmi: assert property (s_fallback |-> nmi_req)
        else $error("fallback without nmi");
    chk_irq_nmi: assert property (irq |-> nmi_req)
        else $error("irq without nmi");
    chk_deep_wait: assert property (sys_reset_req |-> stab_cnt == STAB_CYCLES)
        else $error("reset request inside stabilization wait");
    chk_sample_halt: assert property (sys_reset_req |-> !$past(sample_osc_halted, 3))
        else $error("reset request while sampling clock halted");
    chk_cpu_internal: assert property (sys_reset_req |-> !$past(cpu_on_internal_osc, 3))
        else $error("reset request while cpu on internal oscillator");
    chk_halt_bit: assert property (sys_reset_req |-> !$past(main_osc_halt_bit, 3))
        else $error("reset request while main oscillator halted on purpose");
endmodule // csm_stop_checker
bind csm_clock_stop_monitor csm_stop_checker #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.sys_clk, .rst_b, .main_osc_in,
    .sys_clk_src, .usb_pll_in_use, .deep_stop, .sample_osc_halted, .cpu_on_internal_osc, .main_osc_halt_bit,
    .sys_reset_req, .switch_to_low_speed_internal_osc, .pll_free_run, .usb_pll_free_run, .nmi_req, .irq);

// ---- dv/csm_clock_stop_monitor_bench.sv ----
`timescale 1ns/1ps
`include "csm_consts.vh"
module csm_clock_stop_monitor_bench;
    typedef struct packed {
        logic [1:0] ctrl;
        logic [1:0] src;
        logic       usb;
        logic [2:0] sup;
        logic [4:0] exp;
    } csm_row_t;
    logic       sys_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    wire  [7:0] reg_rdata;
    logic       osc_run = 1'b1;
    wire        main_osc_in;
    logic [1:0] sys_clk_src = 2'h0;
    logic       usb_pll_in_use = 1'b0;
    logic       deep_stop = 1'b0;
    logic [2:0] sup = 3'h0;
    wire  [4:0] outs;
    wire        irq;
    logic [4:0] seen;
    logic [7:0] rdv;
    int         n_errors = 0;
    int         cmp_count = 0;
    int         n;
    csm_row_t   rows [9];
    csm_osc_model u_osc (.sys_clk(sys_clk), .run(osc_run), .osc(main_osc_in));
    csm_clock_stop_monitor #(.STAB_CYCLES(20)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_osc_in(main_osc_in),
        .sys_clk_src(sys_clk_src), .usb_pll_in_use(usb_pll_in_use), .deep_stop(deep_stop),
        .sample_osc_halted(sup[2]), .cpu_on_internal_osc(sup[1]), .main_osc_halt_bit(sup[0]),
        .sys_reset_req(outs[4]), .switch_to_low_speed_internal_osc(outs[3]), .pll_free_run(outs[2]),
        .usb_pll_free_run(outs[1]), .nmi_req(outs[0]), .irq(irq));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic restart(input int cycles);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        osc_run <= 1'b1;
        repeat (cycles) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask
    // The reset request is a single-cycle pulse, so every cycle is sampled and ORed.
    task automatic watch(input int cycles);
        seen = 5'h00;
        osc_run <= 1'b0;
        repeat (cycles) begin
            @(posedge sys_clk);
            #1 seen = seen | outs;
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        rows[0] = '{2'h1, `CSM_SRC_MAIN, 1'b0, 3'h0, 5'h10};
        rows[1] = '{2'h3, `CSM_SRC_MAIN, 1'b0, 3'h0, 5'h09};
        rows[2] = '{2'h3, `CSM_SRC_PLL, 1'b0, 3'h0, 5'h05};
        rows[3] = '{2'h3, `CSM_SRC_LOW_SPEED_INTERNAL_OSC, 1'b1, 3'h0, 5'h03};
        rows[4] = '{2'h3, `CSM_SRC_MAIN, 1'b0, 3'h7, 5'h09};
        rows[5] = '{2'h1, `CSM_SRC_MAIN, 1'b0, 3'h4, 5'h00};
        rows[6] = '{2'h1, `CSM_SRC_MAIN, 1'b0, 3'h2, 5'h00};
        rows[7] = '{2'h1, `CSM_SRC_MAIN, 1'b0, 3'h1, 5'h00};
        rows[8] = '{2'h2, `CSM_SRC_MAIN, 1'b0, 3'h0, 5'h00};
        restart(20);
        rd(`CSM_OFS_CTRL, rdv);
        chk(rdv, `CSM_CTRL_RESET);
        foreach (rows[i]) begin
            restart(2);
            sys_clk_src <= rows[i].src;
            usb_pll_in_use <= rows[i].usb;
            sup <= rows[i].sup;
            wr(`CSM_OFS_CTRL, {6'h00, rows[i].ctrl});
            watch(60);
            chk({3'h0, seen}, {3'h0, rows[i].exp});
            $display("Row %0d done", i);
        end
        restart(2);
        sys_clk_src <= `CSM_SRC_MAIN;
        usb_pll_in_use <= 1'b0;
        sup <= 3'h0;
        wr(`CSM_OFS_CTRL, 8'h03);
        watch(40);
        chk({6'h00, irq, outs[0]}, 8'h01);
        rd(`CSM_OFS_STATUS, rdv);
        chk(rdv, 8'h01);
        rd(`CSM_OFS_STATE, rdv);
        chk(rdv, 8'h25);
        wr(`CSM_OFS_MASK, 8'h01);
        chk({6'h00, irq, outs[0]}, 8'h03);
        wr(`CSM_OFS_STATUS, 8'h01);
        chk({6'h00, irq, outs[0]}, 8'h00);
        rd(8'h10, rdv);
        chk(rdv, 8'h00);
        $display("Interrupt test done");
        restart(2);
        wr(`CSM_OFS_CTRL, 8'h01);
        deep_stop <= 1'b1;
        @(posedge sys_clk);
        deep_stop <= 1'b0;
        osc_run <= 1'b0;
        n = 0;
        while (outs[4] !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n == 200) begin
            n_errors++;
        end else begin
            chk({7'h00, n >= 20 + `CSM_STOP_CYCLES}, 8'h01);
        end
        $display("Deep stop test done");
        test_done;
    end
endmodule // csm_clock_stop_monitor_bench
